// [hdl/flsc_params.svh]
// Constants for the fault log source and erase block
`ifndef FLSC_PARAMS_SVH
`define FLSC_PARAMS_SVH
`define FLSC_SRC_MANUAL 8'hFF
`define FLSC_CH1_OFFSET 8'h10
`define FLSC_LOG_PRESENT_BIT 3
`define FLSC_REC_BYTES 20
`define FLSC_ERASE_LAG (`FLSC_REC_BYTES + 1)
`define FLSC_CLR_TIME_US 8000
`define FLSC_CLK_MHZ 50
`define FLSC_CLR_CYCLES 19'(`FLSC_CLR_TIME_US * `FLSC_CLK_MHZ)
`define FLSC_PTR_W 5
`define FLSC_CNT_W 19
`endif

// [hdl/flsc_pkg.sv]
// Types for the fault log source and erase block
package flsc_pkg;
    typedef enum logic [3:0] {
        FLSC_F_TON_MAX = 4'h0,
        FLSC_F_VOUT_OV = 4'h1,
        FLSC_F_VOUT_UV = 4'h2,
        FLSC_F_IOUT_OC = 4'h3,
        FLSC_F_OT = 4'h5,
        FLSC_F_UT = 4'h6,
        FLSC_F_VIN_OV = 4'h7,
        FLSC_F_DIE_OT = 4'hA
    } flsc_fault_t;
    typedef enum logic [2:0] {
        FLSC_IDLE = 3'b001,
        FLSC_WIPE = 3'b010,
        FLSC_HOLD = 3'b100
    } flsc_state_t;
endpackage

// [hdl/flsc_erase_timer.sv]
// Hold-off timer that delays the log present flag clear after an erase
`include "flsc_params.svh"
module flsc_erase_timer #(
    parameter logic [`FLSC_CNT_W-1:0] CLR_CYCLES = `FLSC_CLR_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic done
);
    logic [`FLSC_CNT_W-1:0] cnt_r; // Cycles left
    logic run_r; // Counting

    // Count down from start, pulse done on expiry
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_r <= CLR_CYCLES - 1'b1;
                run_r <= 1'b1;
            end else if (run_r) begin
                if (cnt_r == '0) begin
                    run_r <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end
endmodule

// [hdl/flsc_core.sv]
// Fault log source tagging, record capture and erase logic
`include "flsc_params.svh"
// Overview of operation
// - Tag log: FF manual, ch1 adds 10
// - Erase command wipes all stored log values
// - Erase clears vendor status log present bit
// - Flag clear completes within 8ms of erase
module flsc_core #(
    parameter logic [`FLSC_CNT_W-1:0] CLR_CYCLES = `FLSC_CLR_CYCLES
) (
    // Clock and synchronous reset
    input wire logic clk,
    input wire logic sys_rst,
    // Log triggers from the fault detectors
    input wire logic fault_evt,
    input wire logic fault_ch,
    input wire flsc_pkg::flsc_fault_t fault_code,
    // Decoded host commands, one cycle strobes
    input wire logic manual_log_store_cmd,
    input wire logic fault_log_erase_cmd,
    // Live telemetry, sampled when a log is taken
    input wire logic [15:0] vout0,
    input wire logic [15:0] vout1,
    input wire logic [15:0] iout0,
    input wire logic [15:0] iout1,
    input wire logic [15:0] vin,
    input wire logic [15:0] iin,
    input wire logic [7:0] status_vout0,
    input wire logic [7:0] status_vout1,
    input wire logic [15:0] status_word0,
    input wire logic [15:0] status_word1,
    input wire logic [7:0] vendor_status_byte0,
    input wire logic [7:0] vendor_status_byte1,
    // Record read port, data one cycle after address
    input wire logic [`FLSC_PTR_W-1:0] rd_addr,
    output logic [7:0] rd_data,
    // Status seen by the host
    output logic [7:0] log_source_r,
    output logic log_present_r,
    output logic erase_busy_r
);
    import flsc_pkg::*;

    // Two paths share the record. A fault or manual strobe copies the live
    // telemetry and tags the source in one edge. An erase command walks a
    // zero through every record byte, then a hold-off timer runs before the
    // log present flag drops. Captures are dropped while the erase runs, so
    // a half-wiped record is never refilled.
    logic [7:0] rec_mem [0:`FLSC_REC_BYTES-1]; // Stored record bytes
    flsc_state_t state_r; // Erase sequencer
    logic [`FLSC_PTR_W-1:0] wipe_ptr_r; // Byte being wiped
    logic timer_start; // Kick hold-off timer
    logic timer_done; // Hold-off expired
    logic capture; // Store event this cycle

    // Index of the last record byte, where the wipe ends
    localparam int LAST_INT = `FLSC_REC_BYTES - 1;
    localparam logic [`FLSC_PTR_W-1:0] LAST_BYTE = LAST_INT[`FLSC_PTR_W-1:0];

    // The flag must be down within the erase window counted from the
    // command edge, so the timer gets the window less the cycles spent
    // wiping and handing over. The window must be longer than that lag.
    localparam int HOLD_INT = int'(CLR_CYCLES) - `FLSC_ERASE_LAG;
    localparam logic [`FLSC_CNT_W-1:0] HOLD_CYCLES = HOLD_INT[`FLSC_CNT_W-1:0]; // Timer load

    // Source code: channel 1 is channel 0 code plus offset
    // Fault codes stay below the offset, so or-ing it adds it
    function automatic logic [7:0] src_code(input logic ch, input flsc_fault_t f);
        logic [7:0] base;
        base = {4'h0, f};
        src_code = ch ? (base | `FLSC_CH1_OFFSET) : base;
    endfunction

    // No capture while an erase is in progress
    assign capture = (fault_evt | manual_log_store_cmd) & (state_r == FLSC_IDLE);
    // Timer kicks off as the last record byte is wiped
    assign timer_start = (state_r == FLSC_WIPE) && (wipe_ptr_r == LAST_BYTE);

    // Source tag of latest log
    // Cleared by reset and by the wipe, set on each capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            log_source_r <= 8'h00;
        end else if (capture) begin
            // Manual store beats a fault in the same cycle
            if (manual_log_store_cmd) begin
                log_source_r <= `FLSC_SRC_MANUAL;
            end else begin
                log_source_r <= src_code(fault_ch, fault_code);
            end
        end else if (state_r == FLSC_WIPE) begin
            // Stale tag goes with the wiped record
            log_source_r <= 8'h00;
        end
    end

    // Record capture and byte wipe
    // No reset here: bytes are unknown until the first capture or erase
    always_ff @(posedge clk) begin
        if (capture) begin
            // Output voltages, high byte first
            rec_mem[0] <= vout0[15:8];
            rec_mem[1] <= vout0[7:0];
            rec_mem[2] <= vout1[15:8];
            rec_mem[3] <= vout1[7:0];
            // Output currents
            rec_mem[4] <= iout0[15:8];
            rec_mem[5] <= iout0[7:0];
            rec_mem[6] <= iout1[15:8];
            rec_mem[7] <= iout1[7:0];
            // Input voltage and current
            rec_mem[8] <= vin[15:8];
            rec_mem[9] <= vin[7:0];
            rec_mem[10] <= iin[15:8];
            rec_mem[11] <= iin[7:0];
            // Output voltage status bytes
            rec_mem[12] <= status_vout0;
            rec_mem[13] <= status_vout1;
            // Status words
            rec_mem[14] <= status_word0[15:8];
            rec_mem[15] <= status_word0[7:0];
            rec_mem[16] <= status_word1[15:8];
            rec_mem[17] <= status_word1[7:0];
            // Vendor status bytes
            rec_mem[18] <= vendor_status_byte0;
            rec_mem[19] <= vendor_status_byte1;
        end else if (state_r == FLSC_WIPE) begin
            // One byte a cycle, pointer walks up from zero
            rec_mem[wipe_ptr_r] <= 8'h00;
        end
    end

    // Read port, out of range reads zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else if (rd_addr < `FLSC_REC_BYTES) begin
            // Inside the record
            rd_data <= rec_mem[rd_addr];
        end else begin
            // Past the last byte
            rd_data <= 8'h00;
        end
    end

    // Erase sequencer: wipe bytes, then hold off flag clear
    // Idle takes the command, wipe spends one cycle per record byte,
    // hold waits for the timer. The flag falls on the edge that
    // returns to idle; busy follows one cycle later.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= FLSC_IDLE;
            wipe_ptr_r <= '0;
        end else begin
            unique case (state_r)
                FLSC_IDLE: begin
                    // Write-only send byte strobe starts erase
                    if (fault_log_erase_cmd) begin
                        state_r <= FLSC_WIPE;
                        wipe_ptr_r <= '0;
                    end
                end
                FLSC_WIPE: begin
                    if (timer_start) begin
                        // Last byte: hand over to the timer
                        state_r <= FLSC_HOLD;
                    end else begin
                        // Step to the next byte
                        wipe_ptr_r <= wipe_ptr_r + 1'b1;
                    end
                end
                FLSC_HOLD: begin
                    if (timer_done) begin
                        // Flag drops on this same edge
                        state_r <= FLSC_IDLE;
                    end
                end
                default: begin
                    // Illegal one-hot code, recover to idle
                    state_r <= FLSC_IDLE;
                end
            endcase
        end
    end

    // Log present flag, set on capture, cleared when hold-off ends
    // A capture wins over the clear, though the sequencer already keeps
    // captures out of the hold state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            log_present_r <= 1'b0;
        end else if (capture) begin
            // New log stored
            log_present_r <= 1'b1;
        end else if (timer_done) begin
            // Hold-off over, flag may drop
            log_present_r <= 1'b0;
        end
    end

    // Busy while erase in progress
    // Goes high the cycle after the command is taken
    // and low one cycle after the sequencer is back in idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            erase_busy_r <= 1'b0;
        end else begin
            erase_busy_r <= (state_r != FLSC_IDLE) || fault_log_erase_cmd;
        end
    end

    // Hold-off timer bounds the flag clear
    // Loaded with the shortened count so the whole erase fits the window
    flsc_erase_timer #(
        .CLR_CYCLES(HOLD_CYCLES)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(timer_start),
        .done(timer_done)
    );
endmodule

// [sim/flsc_core_monitor.sv]
// Checker of fault log tagging and erase timing
module flsc_core_monitor #(
    parameter logic [18:0] CLR_CYCLES = 19'h8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fault_evt,
    input wire logic fault_ch,
    input wire flsc_pkg::flsc_fault_t fault_code,
    input wire logic manual_log_store_cmd,
    input wire logic fault_log_erase_cmd,
    input wire logic [7:0] log_source_r,
    input wire logic log_present_r,
    input wire logic erase_busy_r
);
    import flsc_pkg::*;
    localparam int CLR_LIM = CLR_CYCLES + 1; // Last sample by which the flag must read low
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Capture is taken only while idle
    wire cap_ok = !erase_busy_r && !fault_log_erase_cmd;
    wire erase_take = fault_log_erase_cmd && !erase_busy_r;
    property p_manual;
        manual_log_store_cmd && cap_ok |=> log_source_r == 8'hFF && log_present_r;
    endproperty
    a_manual: assert property (p_manual) else $error("manual source wrong");
    property p_fault;
        fault_evt && !manual_log_store_cmd && cap_ok |=>
            log_source_r == {3'h0, $past(fault_ch), $past(fault_code)};
    endproperty
    a_fault: assert property (p_fault) else $error("fault source wrong");
    property p_wipe;
        erase_take |=> erase_busy_r ##[1:22] log_source_r == 8'h00;
    endproperty
    a_wipe: assert property (p_wipe) else $error("log not wiped");
    property p_clear;
        erase_take |-> ##[1:CLR_LIM] !log_present_r;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_busy_drop;
        $fell(erase_busy_r) |-> !$past(log_present_r);
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("erase ended with flag");
endmodule
bind flsc_core flsc_core_monitor #(.CLR_CYCLES(CLR_CYCLES)) u_flsc_core_monitor (.clk(clk), .sys_rst(sys_rst),
    .fault_evt(fault_evt), .fault_ch(fault_ch), .fault_code(fault_code),
    .manual_log_store_cmd(manual_log_store_cmd), .fault_log_erase_cmd(fault_log_erase_cmd),
    .log_source_r(log_source_r), .log_present_r(log_present_r), .erase_busy_r(erase_busy_r));

// [sim/flsc_host.sv]
// Host model sending the log erase command
module flsc_host (
    input wire logic clk,
    output logic fault_log_erase_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial fault_log_erase_cmd = 1'b0;
    // Send byte: one command pulse, no data, never read back
    task automatic send_erase();
        @(negedge clk);
        fault_log_erase_cmd = 1'b1;
        @(negedge clk);
        fault_log_erase_cmd = 1'b0;
    endtask
endmodule

// [sim/test_flsc_core.sv]
// Self-checking bench of the fault log block
module test_flsc_core;
    timeunit 1ns;
    timeprecision 1ns;
    import flsc_pkg::*;
    logic clk = 0, sys_rst = 1, fault_evt = 0, fault_ch = 0, man = 0, chk = 0, erase_w;
    logic [1:0] sel = 0; // Output picked by the watcher
    logic [7:0] r = 8'h1B, v, got, rd_data, log_source_r;
    logic [4:0] rd_addr = 0;
    logic log_present_r, erase_busy_r;
    flsc_fault_t fault_code = FLSC_F_TON_MAX;
    logic [7:0] q[$]; // Expected results in order
    int fails = 0, checks = 0;
    always #10 clk = ~clk;
    function automatic logic [7:0] lfsr(logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    flsc_core #(.CLR_CYCLES(19'h40)) u_flsc_core (.clk(clk), .sys_rst(sys_rst), .fault_evt(fault_evt),
        .fault_ch(fault_ch), .fault_code(fault_code), .manual_log_store_cmd(man), .fault_log_erase_cmd(erase_w),
        .vout0({r, ~r}), .vout1({r, r}), .iout0({~r, r}), .iout1({r, r}), .vin({r, r}), .iin({r, r}),
        .status_vout0(r), .status_vout1(r), .status_word0({r, r}), .status_word1({r, r}),
        .vendor_status_byte0(r), .vendor_status_byte1(~r), .rd_addr(rd_addr), .rd_data(rd_data),
        .log_source_r(log_source_r), .log_present_r(log_present_r), .erase_busy_r(erase_busy_r));
    flsc_host u_flsc_host (.clk(clk), .fault_log_erase_cmd(erase_w));
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Note an expectation and flag the watcher
    task automatic note(logic [7:0] e, logic [1:0] s);
        q.push_back(e);
        sel = s;
        chk = 1;
        @(negedge clk);
        chk = 0;
    endtask
    task automatic cap(logic ch, logic m, logic [7:0] e);
        r = lfsr(r);
        fault_ch = ch;
        fault_evt = 1;
        man = m;
        @(negedge clk);
        fault_evt = 0;
        man = 0;
        note(e, 0);
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] e);
        rd_addr = a;
        @(negedge clk);
        note(e, 1);
    endtask
    // Watcher compares the oldest note with the settled output
    always @(posedge clk) begin
        if (chk) begin
            v = q.pop_front();
            got = sel == 3 ? {7'h0, erase_busy_r} :
                sel == 2 ? {7'h0, log_present_r} : sel == 1 ? rd_data : log_source_r;
            checks++;
            if (got !== v) begin
                $display("[FAIL] %0t got %h exp %h", $time, got, v);
                fails++;
            end
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 0;
        for (int c = 0; c < 2; c++) begin
            fault_code = fault_code.first();
            repeat (8) begin
                cap(c[0], 0, {3'h0, c[0], fault_code});
                fault_code = fault_code.next();
            end
        end
        cap(1, 1, 8'hFF);
        rd(5'h00, r);
        rd(5'h01, ~r);
        rd(5'h13, ~r);
        rd(5'h14, 8'h00);
        note(8'h01, 2);
        u_flsc_host.send_erase();
        fault_evt = 1; // Dropped while erasing
        note(8'h01, 3);
        fault_evt = 0;
        repeat (23) @(negedge clk);
        note(8'h00, 0);
        rd(5'h00, 8'h00);
        rd(5'h13, 8'h00);
        repeat (40) @(negedge clk);
        note(8'h00, 2);
        note(8'h00, 3);
        tally_and_finish();
    end
    initial begin
        #100us;
        fails++;
        $display("[FAIL] %0t watchdog", $time);
        tally_and_finish();
    end
endmodule
